// [logic/pdd_pkg.sv]
`default_nettype none

// ==========================================================================
// Port direction and data register constants
// ==========================================================================
package pdd_pkg;

   // Number of controlled ports: 1, 2, 3, 4, 8, 10, 11, 12, 14, 15
   localparam int PDD_NPORT = 10;

   // Direction register addresses, index 0 is port 1
   localparam logic [15:0] PDD_DIR_OFS [PDD_NPORT] = '{
      16'hff21, 16'hff22, 16'hff23, 16'hff24, 16'hff28,
      16'hff2a, 16'hff2b, 16'hff2c, 16'hff2e, 16'hff2f};

   // Data register addresses, same port order
   localparam logic [15:0] PDD_DAT_OFS [PDD_NPORT] = '{
      16'hff01, 16'hff02, 16'hff03, 16'hff04, 16'hff08,
      16'hff0a, 16'hff0b, 16'hff0c, 16'hff0e, 16'hff0f};

   // Implemented direction bits per port; a 0 bit is held at 1
   localparam logic [7:0] PDD_DIR_IMPL [PDD_NPORT] = '{
      8'h1e, 8'hff, 8'h1e, 8'h1f, 8'h0f,
      8'h0f, 8'h0f, 8'h01, 8'h0f, 8'h0f};

   // Reset values
   localparam logic [7:0] PDD_DIR_RST  = 8'hff;
   localparam logic [7:0] PDD_DAT_RST  = 8'h00;
   localparam logic [7:0] PDD_SYNC_RST = 8'h00;
   localparam logic [7:0] PDD_RD_RST   = 8'h00;

   // Read answer for an address that no register decodes
   localparam logic [7:0] PDD_RD_UNMAPPED = 8'h00;

   // Bit position of a single-bit write value within the write data
   localparam int PDD_BIT_VAL_POS = 0;

   // Processor memory-manipulation request, one cycle wide
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        bit_op;
      logic [2:0]  bit_sel;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } pdd_req_t;

endpackage : pdd_pkg

`default_nettype wire

// [logic/pdd_port.sv]
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// One port: direction register, output latch, pin synchroniser
// ==========================================================================
module pdd_port #(
   parameter logic [7:0] IMPL = 8'hff
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Write strobes from address decode
   input  wire logic       dir_we,
   input  wire logic       dat_we,
   input  wire logic       bit_op,
   input  wire logic [2:0] bit_sel,
   input  wire logic [7:0] wdata,
   // Pin side
   input  wire logic [7:0] pin_in,
   output logic      [7:0] pin_out,
   output logic      [7:0] pin_oe,
   // State seen by the read mux
   output logic      [7:0] dir,
   output logic      [7:0] lat,
   output logic      [7:0] pin_lvl
);

   logic [7:0] dir_q;
   logic [7:0] dir_d;
   logic [7:0] lat_q;
   logic [7:0] lat_d;
   logic [7:0] sync1_q;
   logic [7:0] sync2_q;
   logic [7:0] bit_mask;
   logic [7:0] bit_val;
   logic [7:0] dir_wr;
   logic [7:0] lat_wr;

   // Single-bit writes touch only the selected bit
   assign bit_mask = 8'h01 << bit_sel;                              // R3
   assign bit_val  = wdata[pdd_pkg::PDD_BIT_VAL_POS] ? bit_mask : 8'h00;
   assign dir_wr   = bit_op ? ((dir_q & ~bit_mask) | bit_val) : wdata; // R1
   assign lat_wr   = bit_op ? ((lat_q & ~bit_mask) | bit_val) : wdata; // R3

   // Unimplemented direction bits stay at 1 whatever is written
   assign dir_d = (dir_we ? dir_wr : dir_q) | ~IMPL;                // R11
   assign lat_d = dat_we ? lat_wr : lat_q;                          // R7

   // Registers; pins pass two flops before anything reads them
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         dir_q   <= pdd_pkg::PDD_DIR_RST;                           // R4
         lat_q   <= pdd_pkg::PDD_DAT_RST;                           // R10
         sync1_q <= pdd_pkg::PDD_SYNC_RST;
         sync2_q <= pdd_pkg::PDD_SYNC_RST;
      end
      else
      begin
         dir_q   <= dir_d;
         lat_q   <= lat_d;
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // Direction 0 turns the buffer on and drives the latch
   assign pin_out = lat_q;                                          // R7
   assign pin_oe  = ~dir_q;                                         // R2
   assign dir     = dir_q;
   assign lat     = lat_q;
   assign pin_lvl = sync2_q;

endmodule : pdd_port

`default_nettype wire

// [logic/pdd_regs.sv]
// Behaviour
// R1: Each pin has its own direction bit, set independently.
// R2: Direction 0 enables the output buffer; 1 disables it, pin is input.
// R3: Both registers take single-bit and byte writes; bit writes spare others.
// R4: Reset loads every direction register with all ones.
// R5: Software writes 1 to unimplemented direction bits.
// R6: Software sets direction bits as alternate functions require.
// R7: Data writes update the latch, driven on output-mode pins.
// R8: Data reads of input-mode bits return the synchronised pin level.
// R9: Data reads of output-mode bits return the latch value.
// R10: Reset clears every output latch to zero.
// R11: Unimplemented direction bits hold and read back 1.
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Port direction and data registers, top level
// ==========================================================================
module pdd_regs (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Processor request and read answer
   input  wire pdd_pkg::pdd_req_t req,
   output logic [7:0]             rd_data,
   output logic                   rd_valid,
   // Port pins, index 0 is port 1
   input  wire logic [pdd_pkg::PDD_NPORT-1:0][7:0] pin_in,
   output logic      [pdd_pkg::PDD_NPORT-1:0][7:0] pin_out,
   output logic      [pdd_pkg::PDD_NPORT-1:0][7:0] pin_oe
);

   localparam int NP = pdd_pkg::PDD_NPORT;

   logic [NP-1:0]      dir_hit;
   logic [NP-1:0]      dat_hit;
   logic [NP-1:0][7:0] dir;
   logic [NP-1:0][7:0] lat;
   logic [NP-1:0][7:0] pin_lvl;
   logic [7:0]         sel_dir;
   logic [7:0]         sel_lat;
   logic [7:0]         sel_pin;
   logic [7:0]         sel_rd;
   logic               any_dir;
   logic               any_dat;
   logic [7:0]         rd_data_q;
   logic [7:0]         rd_data_d;
   logic               rd_valid_q;

   // ==========================================================================
   // Address decode and per-port instances
   // ==========================================================================
   genvar p;
   generate
      for (p = 0; p < NP; p++)
      begin : g_port
         // Exact match only; nearby addresses belong to other blocks
         assign dir_hit[p] = (req.addr == pdd_pkg::PDD_DIR_OFS[p]);
         assign dat_hit[p] = (req.addr == pdd_pkg::PDD_DAT_OFS[p]);

         pdd_port #(
            .IMPL (pdd_pkg::PDD_DIR_IMPL[p])
         ) u_port (
            .clk     (clk),
            .rst_n   (rst_n),
            .dir_we  (req.wr && dir_hit[p]),
            .dat_we  (req.wr && dat_hit[p]),
            .bit_op  (req.bit_op),
            .bit_sel (req.bit_sel),
            .wdata   (req.wdata),
            .pin_in  (pin_in[p]),
            .pin_out (pin_out[p]),
            .pin_oe  (pin_oe[p]),
            .dir     (dir[p]),
            .lat     (lat[p]),
            .pin_lvl (pin_lvl[p])
         );
      end
   endgenerate

   // ==========================================================================
   // Read selection
   // ==========================================================================
   // Hits are one-hot, so an OR of masked words is the mux
   always_comb
   begin
      sel_dir = 8'h00;
      sel_lat = 8'h00;
      sel_pin = 8'h00;
      any_dir = 1'b0;
      any_dat = 1'b0;
      for (int i = 0; i < NP; i++)
      begin
         if (dir_hit[i])
         begin
            any_dir = 1'b1;
            sel_dir = sel_dir | dir[i];
         end
         if (dat_hit[i])
         begin
            any_dat = 1'b1;
            sel_dir = sel_dir | dir[i];
            sel_lat = sel_lat | lat[i];
            sel_pin = sel_pin | pin_lvl[i];
         end
      end
   end

   // Input bits show the pin, output bits show the latch
   assign sel_rd = any_dir ? sel_dir :
                   any_dat ? ((sel_dir & sel_pin) | (~sel_dir & sel_lat)) : // R8 R9
                   pdd_pkg::PDD_RD_UNMAPPED;
   assign rd_data_d = req.rd ? sel_rd : rd_data_q;

   // Read data is registered; it holds until the next read
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rd_data_q  <= pdd_pkg::PDD_RD_RST;
         rd_valid_q <= 1'b0;
      end
      else
      begin
         rd_data_q  <= rd_data_d;
         rd_valid_q <= req.rd;
      end
   end

   assign rd_data  = rd_data_q;
   assign rd_valid = rd_valid_q;

   // ==========================================================================
   // Checks
   // ==========================================================================
   // Port 2 has every direction bit implemented, so it is watched closely
   localparam int WP = 1;

   logic [NP-1:0] impl_ok;
   logic [NP-1:0] oe_ok;
   logic [NP-1:0] drv_ok;
   generate
      for (p = 0; p < NP; p++)
      begin : g_chk
         assign impl_ok[p] = ((dir[p] | pdd_pkg::PDD_DIR_IMPL[p]) == 8'hff);
         assign oe_ok[p]   = (pin_oe[p] == ~dir[p]);
         assign drv_ok[p]  = (pin_out[p] == lat[p]);
      end
   endgenerate

   default clocking cb @(posedge clk);
   endclocking

   sequence s_rst_release;
      !rst_n ##1 rst_n;
   endsequence

   sequence s_byte_wr_dat;
      req.wr && !req.bit_op && dat_hit[WP];
   endsequence

   sequence s_bit_wr_dir;
      req.wr && req.bit_op && dir_hit[WP];
   endsequence

   sequence s_rd_dat;
      req.rd && any_dat && !(req.wr);
   endsequence

   rst_dir_a: assert property ( // R4
      s_rst_release |-> (dir[WP] == pdd_pkg::PDD_DIR_RST) && (pin_oe == '0))
      else $error("direction not all ones after reset");

   rst_lat_a: assert property ( // R10
      s_rst_release |-> (lat[WP] == pdd_pkg::PDD_DAT_RST) && (pin_out == '0))
      else $error("output latch not cleared after reset");

   oe_dir_a: assert property (disable iff (!rst_n) // R2
      (&oe_ok) && (&drv_ok))
      else $error("output enable or drive does not follow direction");

   unimpl_one_a: assert property (disable iff (!rst_n) // R11
      &impl_ok)
      else $error("unimplemented direction bit reads zero");

   byte_latch_a: assert property (disable iff (!rst_n) // R7
      s_byte_wr_dat |=> (pin_out[WP] == $past(req.wdata)) ##1
                        (pin_out[WP] == $past(req.wdata, 2)) || $past(req.wr))
      else $error("byte write not driven from latch");

   bit_keep_a: assert property (disable iff (!rst_n) // R1
      s_bit_wr_dir |=>
         ((dir[WP] ^ $past(dir[WP])) & ~(8'h01 << $past(req.bit_sel))) == 8'h00
         && dir[WP][$past(req.bit_sel)] == $past(req.wdata[0]))
      else $error("single-bit write disturbed other bits");

   rd_input_a: assert property (disable iff (!rst_n) // R8
      s_rd_dat |=> rd_valid && ((rd_data & $past(sel_dir)) ==
                                ($past(sel_pin) & $past(sel_dir))))
      else $error("input-mode read is not the pin level");

   rd_output_a: assert property (disable iff (!rst_n) // R9
      s_rd_dat |=> (rd_data & ~$past(sel_dir)) == ($past(sel_lat) & ~$past(sel_dir)))
      else $error("output-mode read is not the latch value");

   rd_unmapped_a: assert property (disable iff (!rst_n) // R3
      req.rd && !any_dir && !any_dat |=> rd_data == pdd_pkg::PDD_RD_UNMAPPED)
      else $error("unmapped read not zero");

   // ==========================================================================
   // Checks on write effects, the read answer and the pin path
   // ==========================================================================
   // Every port, not only the watched one: a decode slip on one address
   // would otherwise pass unseen
   generate
      for (p = 0; p < NP; p++)
      begin : g_wr_chk
         dat_wr_a: assert property (disable iff (!rst_n) // R7
            req.wr && !req.bit_op && dat_hit[p] |=> pin_out[p] == $past(req.wdata))
            else $error("byte data write not driven on the pins");

         dir_wr_a: assert property (disable iff (!rst_n) // R11
            req.wr && !req.bit_op && dir_hit[p] |=>
               dir[p] == ($past(req.wdata) | ~pdd_pkg::PDD_DIR_IMPL[p]))
            else $error("byte direction write not kept as written");
      end
   endgenerate

   // Reference delay line for the synchroniser; a missing or extra flop
   // would slip past the read tests, which wait long enough either way
   logic [NP-1:0][7:0] ref1_q;
   logic [NP-1:0][7:0] ref2_q;

   // Same reset as the synchroniser, so no false alarm after release
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ref1_q <= {NP{pdd_pkg::PDD_SYNC_RST}};
         ref2_q <= {NP{pdd_pkg::PDD_SYNC_RST}};
      end
      else
      begin
         ref1_q <= pin_in;
         ref2_q <= ref1_q;
      end
   end

   // Steps of the watched-port writes, of unmapped writes and of idle read cycles
   sequence s_byte_wr_dir;
      req.wr && !req.bit_op && dir_hit[WP];
   endsequence

   sequence s_bit_wr_dat;
      req.wr && req.bit_op && dat_hit[WP];
   endsequence

   sequence s_no_rd;
      !req.rd;
   endsequence

   sequence s_unmapped_wr;
      req.wr && !(|dir_hit) && !(|dat_hit);
   endsequence

   // All ports at once, since one missed reset term hides in a single port
   rst_all_a: assert property ( // R4
      s_rst_release |-> (dir == {NP{pdd_pkg::PDD_DIR_RST}}) &&
                        (lat == {NP{pdd_pkg::PDD_DAT_RST}}) && !rd_valid)
      else $error("ports or read answer not at reset values");

   dir_oe_a: assert property (disable iff (!rst_n) // R2
      s_byte_wr_dir |=> pin_oe[WP] == ~$past(req.wdata))
      else $error("byte direction write not seen on the output enable");

   lat_bit_a: assert property (disable iff (!rst_n) // R3
      s_bit_wr_dat |=>
         ((lat[WP] ^ $past(lat[WP])) & ~(8'h01 << $past(req.bit_sel))) == 8'h00
         && lat[WP][$past(req.bit_sel)] == $past(req.wdata[0]))
      else $error("single-bit data write disturbed other bits");

   unmapped_wr_a: assert property (disable iff (!rst_n) // R7
      s_unmapped_wr |=> $stable(dir) && $stable(lat))
      else $error("write to an unmapped place changed a port");

   rd_pulse_a: assert property (disable iff (!rst_n) // R8
      s_no_rd |=> !rd_valid)
      else $error("read answer without a read");

   // Read data is held, so a slow reader may take it late
   rd_hold_a: assert property (disable iff (!rst_n) // R9
      s_no_rd |=> $stable(rd_data))
      else $error("read data changed without a read");

   rd_dir_a: assert property (disable iff (!rst_n) // R11
      req.rd && dir_hit[WP] |=> rd_valid && rd_data == $past(dir[WP]))
      else $error("direction read does not return the register");

   sync_lag_a: assert property (disable iff (!rst_n) // R8
      pin_lvl == ref2_q)
      else $error("pin level not two flops behind the pin");

endmodule : pdd_regs

`default_nettype wire

// [testbench/pdd_pin_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Pin-side model: a driven pin shows the latch, else the outside level
// ==========================================================================
module pdd_pin_model (
   // Device pins
   input  wire logic [pdd_pkg::PDD_NPORT-1:0][7:0] pin_out,
   input  wire logic [pdd_pkg::PDD_NPORT-1:0][7:0] pin_oe,
   // Level the outside world puts on undriven pins
   input  wire logic [pdd_pkg::PDD_NPORT-1:0][7:0] ext_lvl,
   output logic      [pdd_pkg::PDD_NPORT-1:0][7:0] pin_in
);
   // Per-bit wire resolution; no contention is modelled
   assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule : pdd_pin_model

`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Bench for the port direction and data registers
// ==========================================================================
module testbench;
   localparam int NP = pdd_pkg::PDD_NPORT;
   logic               clk;
   logic               rst_n;
   pdd_pkg::pdd_req_t  req;
   logic [7:0]         rd_data;
   logic               rd_valid;
   logic [NP-1:0][7:0] pin_in;
   logic [NP-1:0][7:0] pin_out;
   logic [NP-1:0][7:0] pin_oe;
   logic [NP-1:0][7:0] ext_lvl;
   logic [7:0]         dir_m [NP];
   logic [7:0]         lat_m [NP];
   logic [7:0]         got;
   int                 n_errors;
   int                 check_count;
   int                 p;

   pdd_regs u_pdd_regs (.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
      .rd_valid(rd_valid), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

   pdd_pin_model u_pdd_pin_model (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_lvl(ext_lvl), .pin_in(pin_in));

   // Clock, 100 ns period
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ==========================================================================
   // Reporting and bus tasks
   // ==========================================================================
   task automatic give_verdict;
      if (n_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One request, then the read answer one edge later
   task automatic access(input logic w, r, b, input logic [2:0] s,
                         input logic [15:0] a, input logic [7:0] d);
      int i;
      @(posedge clk);
      req <= '{wr: w, rd: r, bit_op: b, bit_sel: s, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
      #1;
      // Bounded wait, a stuck rd_valid ends the run
      for (i = 0; r && i < 4 && rd_valid !== 1'b1; i++)
         @(posedge clk);
      if (r && rd_valid !== 1'b1)
      begin
         n_errors++;
         give_verdict();
      end
      got = rd_data;
   endtask : access

   // Write and mirror it; unimplemented direction bits stay set
   task automatic wr_reg(input logic is_dir, input int q, input logic b,
                         input logic [2:0] s, input logic [7:0] d);
      logic [7:0] v;
      v = is_dir ? dir_m[q] : lat_m[q];
      if (b)
         v[s] = d[0];
      else
         v = d;
      if (is_dir)
         dir_m[q] = v | ~pdd_pkg::PDD_DIR_IMPL[q];
      else
         lat_m[q] = v;
      access(1'b1, 1'b0, b, s, is_dir ? pdd_pkg::PDD_DIR_OFS[q] : pdd_pkg::PDD_DAT_OFS[q], d);
   endtask : wr_reg

   function automatic logic [7:0] exp_dat(input int q);
      return (lat_m[q] & ~dir_m[q]) | (ext_lvl[q] & dir_m[q]);
   endfunction : exp_dat

   task automatic chk_port(input int q);
      access(1'b0, 1'b1, 1'b0, 3'h0, pdd_pkg::PDD_DIR_OFS[q], 8'h00);
      check(got, dir_m[q]);
      access(1'b0, 1'b1, 1'b0, 3'h0, pdd_pkg::PDD_DAT_OFS[q], 8'h00);
      check(got, exp_dat(q));
      check(pin_oe[q], ~dir_m[q]);
      check(pin_out[q], lat_m[q]);
   endtask : chk_port

   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      foreach (dir_m[i])
      begin
         dir_m[i] = 8'hff;
         lat_m[i] = 8'h00;
      end
   endtask : do_reset

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial
   begin
      n_errors = 0;
      check_count = 0;
      void'($urandom(32'h85d78d1f));
      rst_n = 1'b0;
      req = '0;
      foreach (ext_lvl[i])
         ext_lvl[i] = 8'($urandom());
      do_reset();
      for (p = 0; p < NP; p++)
         chk_port(p);
      // Walk single-bit writes over every bit of port 2
      for (p = 0; p < 8; p++)
      begin
         wr_reg(1'b1, 1, 1'b1, 3'(p), 8'h00);
         wr_reg(1'b0, 1, 1'b1, 3'(p), 8'(p & 1));
         chk_port(1);
      end
      // Byte writes on port 2: direction first, then data, as a pin setup does
      wr_reg(1'b1, 1, 1'b0, 3'h0, 8'hf0);
      wr_reg(1'b0, 1, 1'b0, 3'h0, 8'ha5);
      chk_port(1);
      // Random traffic; odd passes may write 0 into unimplemented bits
      for (p = 0; p < 60; p++)
      begin : rnd
         int q;
         logic [7:0] d;
         q = $urandom_range(NP - 1, 0);
         d = 8'($urandom());
         if (p[0] == 1'b0)
            d = d | ~pdd_pkg::PDD_DIR_IMPL[q];
         wr_reg(1'($urandom()), q, 1'($urandom()), 3'($urandom()), d);
         if (p % 8 == 0)
         begin
            ext_lvl[q] <= 8'($urandom());
            repeat (3) @(posedge clk);
         end
         chk_port(q);
      end
      // Unmapped places: read gives 00, write changes nothing
      access(1'b0, 1'b1, 1'b0, 3'h0, 16'hff20, 8'h00);
      check(got, pdd_pkg::PDD_RD_UNMAPPED);
      access(1'b1, 1'b0, 1'b0, 3'h0, 16'hff25, 8'h00);
      for (p = 0; p < NP; p++)
         chk_port(p);
      // Reset in mid-run restores every port
      do_reset();
      for (p = 0; p < NP; p++)
         chk_port(p);
      give_verdict();
   end
endmodule : testbench

`default_nettype wire
